// file: op_sequencer.sv
// bus controller op code sequencer: fetch, decode, condition, stack, gap timer
//
// Function
// - cond 0xC tests format/no-reply/loopback error
// - masked status never affects bad message
// - cond 0xD: one or more retries; inverse zero
// - cond 0xE: exactly two retries
// - cond 0xF always; inverted is never true, a no-op for all but the unconditional ops
// - instruction field is bits 14 to 10
// - timer compares, flag bits, flip run unconditionally
// - others run only when condition true
// - parameter word always follows op code, used or not
// - eight-deep call stack, fault on over/underflow
// - irq op writes 4-bit code to pending
// - op 0x01 runs addressed message block
// - nonzero fourth block word loads message timer
// - no fetch until message timer reaches zero
// - flag, counter load, frame, trigger, compare ops
// - flags changed by instruction or host write
// - no-reply flag tested from message engine
`timescale 1ns/100ps
module op_sequencer
	import op_seq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              start,
	input  wire logic              ext_trigger,
	input  wire logic              stack_irq_enable,
	input  wire logic              host_flag_wr,
	input  wire logic [7:0]        host_flag_data,
	input  wire logic [WORD_W-1:0] ram_rdata,
	input  wire logic              ram_rvalid,
	input  wire logic              msg_done,
	input  wire logic              no_reply_flag,
	input  wire logic              format_fault_flag,
	input  wire logic              error_free_read_flag,
	input  wire logic              masked_status_flag,
	input  wire logic              loopback_fault,
	input  wire logic [1:0]        retry_count,
	input  wire logic [WORD_W-1:0] frame_time_left,
	output logic                   ram_rd,
	output logic [ADDR_W-1:0]      ram_addr,
	output logic                   msg_start,
	output logic [ADDR_W-1:0]      msg_block_addr,
	output logic                   ttag_load,
	output logic                   frame_load,
	output logic                   frame_start,
	output logic [WORD_W-1:0]      load_value,
	output logic [7:0]             general_flags,
	output logic [IRQ_CODE_W-1:0]  irq_code,
	output logic                   irq_req,
	output logic                   call_stack_fault_irq,
	output logic                   busy,
	output logic                   halted
);
	seq_state_e              state_r, state_nxt;
	logic [ADDR_W-1:0]       pc_r, pc_nxt;
	logic [WORD_W-1:0]       op_r, op_nxt;
	logic [WORD_W-1:0]       param_r, param_nxt;
	logic [WORD_W-1:0]       msg_timer_r, msg_timer_nxt;
	logic [ADDR_W-1:0]       stack_r [STACK_DEPTH];
	logic [STACK_PTR_W-1:0]  sp_r, sp_nxt;
	logic                    push, pop;
	logic [7:0]              flags_r, flags_nxt;
	logic [IRQ_CODE_W-1:0]   irq_r, irq_nxt;
	logic                    irq_req_r, irq_req_nxt;
	logic                    stk_r, stk_nxt;
	logic                    rd_r, rd_nxt;
	logic [ADDR_W-1:0]       addr_r, addr_nxt;
	logic                    mst_r, mst_nxt, tl_r, tl_nxt, fl_r, fl_nxt, fs_r, fs_nxt;
	logic [4:0]              instr;
	logic                    cond_true, uncond, go;
	logic                    busy_r, busy_nxt, halt_r, halt_nxt;
	assign instr  = op_r[INSTR_MSB:INSTR_LSB];
	assign uncond = (instr == OP_CMP_MSG_TMR) || (instr == OP_CMP_FRM_TMR)
		|| (instr == OP_FLAG_BITS) || (instr == OP_EXEC_FLIP);
	assign go     = uncond || cond_true;
	cond_eval u_cond (
		.cond_code            (op_r[COND_MSB:0]),
		.general_flags        (flags_r),
		.no_reply_flag        (no_reply_flag),
		.format_fault_flag    (format_fault_flag),
		.error_free_read_flag (error_free_read_flag),
		.masked_status_flag   (masked_status_flag),
		.loopback_fault       (loopback_fault),
		.retry_count          (retry_count),
		.cond_true            (cond_true)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_nxt     = state_r;
		pc_nxt        = pc_r;
		op_nxt        = op_r;
		param_nxt     = param_r;
		sp_nxt        = sp_r;
		push          = 1'b0;
		pop           = 1'b0;
		flags_nxt     = flags_r;
		irq_nxt       = irq_r;
		irq_req_nxt   = 1'b0;
		stk_nxt       = 1'b0;
		rd_nxt        = 1'b0;
		addr_nxt      = addr_r;
		mst_nxt       = 1'b0;
		tl_nxt        = 1'b0;
		fl_nxt        = 1'b0;
		fs_nxt        = 1'b0;
		msg_timer_nxt = (msg_timer_r != '0) ? msg_timer_r - 16'h0001 : msg_timer_r;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					pc_nxt    = LIST_START;
					state_nxt = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// gap timer gates every fetch
				if (msg_timer_r == '0 && !rd_r) begin
					rd_nxt    = 1'b1;
					addr_nxt  = pc_r;
					state_nxt = ST_DECODE;
				end
			end
			ST_DECODE: begin
				if (ram_rvalid) begin
					op_nxt    = ram_rdata;
					rd_nxt    = 1'b1;
					addr_nxt  = pc_r + 16'h0001;
					pc_nxt    = pc_r + 16'h0002;
					state_nxt = ST_PARAM;
				end
			end
			ST_PARAM: begin
				if (ram_rvalid) begin
					param_nxt = ram_rdata;
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_nxt = ST_FETCH;
				if (go) begin
					case (instr)
						OP_EXEC_MSG, OP_EXEC_FLIP: begin
							rd_nxt    = 1'b1;
							addr_nxt  = param_r + 16'(MSG_TIME_WORD);
							state_nxt = ST_MSG_RD;
						end
						OP_JUMP: pc_nxt = param_r;
						OP_CALL: begin
							if (sp_r == 4'(STACK_DEPTH)) begin
								stk_nxt = stack_irq_enable;
							end else begin
								push   = 1'b1;
								sp_nxt = sp_r + 4'h1;
								pc_nxt = param_r;
							end
						end
						OP_RETURN: begin
							if (sp_r == 4'h0) begin
								stk_nxt = stack_irq_enable;
							end else begin
								pop    = 1'b1;
								sp_nxt = sp_r - 4'h1;
								pc_nxt = stack_r[3'(sp_r - 4'h1)];
							end
						end
						OP_HALT: state_nxt = ST_HALTED;
						OP_IRQ: begin
							irq_nxt     = param_r[IRQ_CODE_W-1:0];
							irq_req_nxt = 1'b1;
						end
						// compares drive the two shared flags
						OP_CMP_MSG_TMR: begin
							flags_nxt[0] = msg_timer_r < param_r;
							flags_nxt[1] = msg_timer_r == param_r;
						end
						OP_CMP_FRM_TMR: begin
							flags_nxt[0] = frame_time_left < param_r;
							flags_nxt[1] = frame_time_left == param_r;
						end
						// low byte sets, high byte clears, both toggles
						OP_FLAG_BITS: flags_nxt = ((flags_r | param_r[7:0]) & ~param_r[15:8])
							| (param_r[15:8] & param_r[7:0] & ~flags_r);
						OP_LOAD_TTAG:   tl_nxt = 1'b1;
						OP_LOAD_FRAME:  fl_nxt = 1'b1;
						OP_START_FRAME: fs_nxt = 1'b1;
						OP_WAIT_TRIG:   state_nxt = ST_TRIG;
						default: ;
					endcase
				end
			end
			ST_MSG_RD: begin
				if (ram_rvalid) begin
					if (ram_rdata != '0) begin
						msg_timer_nxt = ram_rdata;
					end
					mst_nxt   = 1'b1;
					state_nxt = ST_MSG_RUN;
				end
			end
			ST_MSG_RUN: begin
				if (msg_done) begin
					if (instr == OP_EXEC_FLIP) begin
						flags_nxt[0] = ~flags_r[0];
					end
					state_nxt = ST_FETCH;
				end
			end
			ST_TRIG: begin
				if (ext_trigger) begin
					fs_nxt    = 1'b1;
					state_nxt = ST_FETCH;
				end
			end
			ST_HALTED: begin
				if (start) begin
					state_nxt = ST_FETCH;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// host write wins over instruction update
		if (host_flag_wr) begin
			flags_nxt = host_flag_data;
		end
		busy_nxt = (state_nxt != ST_IDLE) && (state_nxt != ST_HALTED);
		halt_nxt = (state_nxt == ST_HALTED);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r     <= ST_IDLE;
			pc_r        <= LIST_START;
			op_r        <= '0;
			param_r     <= '0;
			msg_timer_r <= '0;
			sp_r        <= '0;
			flags_r     <= GFLAG_RESET;
			irq_r       <= IRQ_RESET;
			irq_req_r   <= 1'b0;
			stk_r       <= 1'b0;
			rd_r        <= 1'b0;
			addr_r      <= '0;
			mst_r       <= 1'b0;
			tl_r        <= 1'b0;
			fl_r        <= 1'b0;
			fs_r        <= 1'b0;
			busy_r      <= 1'b0;
			halt_r      <= 1'b0;
		end else if (ce) begin
			state_r     <= state_nxt;
			pc_r        <= pc_nxt;
			op_r        <= op_nxt;
			param_r     <= param_nxt;
			msg_timer_r <= msg_timer_nxt;
			sp_r        <= sp_nxt;
			flags_r     <= flags_nxt;
			irq_r       <= irq_nxt;
			irq_req_r   <= irq_req_nxt;
			stk_r       <= stk_nxt;
			rd_r        <= rd_nxt;
			addr_r      <= addr_nxt;
			mst_r       <= mst_nxt;
			tl_r        <= tl_nxt;
			fl_r        <= fl_nxt;
			fs_r        <= fs_nxt;
			busy_r      <= busy_nxt;
			halt_r      <= halt_nxt;
		end
	end

	// return stack holds the address after the call
	always_ff @(posedge clk) begin
		if (ce && push) begin
			stack_r[3'(sp_r)] <= pc_r;
		end
	end
	assign ram_rd               = rd_r;
	assign ram_addr             = addr_r;
	assign msg_start            = mst_r;
	assign msg_block_addr       = param_r;
	assign ttag_load            = tl_r;
	assign frame_load           = fl_r;
	assign frame_start          = fs_r;
	assign load_value           = param_r;
	assign general_flags        = flags_r;
	assign irq_code             = irq_r;
	assign irq_req              = irq_req_r;
	assign call_stack_fault_irq = stk_r;
	assign busy                 = busy_r;
	assign halted               = halt_r;
endmodule : op_sequencer

// file: op_seq_pkg.sv
// constants for the bus controller op code sequencer
package op_seq_pkg;
	localparam int          WORD_W         = 16;
	localparam int          ADDR_W         = 16;
	localparam int          INSTR_MSB      = 14;
	localparam int          INSTR_LSB      = 10;
	localparam int          COND_MSB       = 4;
	localparam int          COND_INV_BIT   = 4;
	localparam int          STACK_DEPTH    = 8;
	localparam int          STACK_PTR_W    = 4;
	localparam int          IRQ_CODE_W     = 4;
	localparam int          MSG_TIME_WORD  = 3;
	localparam logic [15:0] LIST_START     = 16'h0000;
	localparam logic [3:0]  IRQ_RESET      = 4'h0;
	localparam logic [7:0]  GFLAG_RESET    = 8'h00;

	// condition selects
	localparam logic [3:0] COND_NO_REPLY   = 4'h8;
	localparam logic [3:0] COND_FORMAT     = 4'h9;
	localparam logic [3:0] COND_ERROR_FREE_READ_FLAG  = 4'hA;
	localparam logic [3:0] COND_MASKED     = 4'hB;
	localparam logic [3:0] COND_BAD_MSG    = 4'hC;
	localparam logic [3:0] COND_RETRY_1    = 4'hD;
	localparam logic [3:0] COND_RETRY_2    = 4'hE;
	localparam logic [3:0] COND_ALWAYS     = 4'hF;

	// instruction codes
	localparam logic [4:0] OP_EXEC_MSG     = 5'h01;
	localparam logic [4:0] OP_JUMP         = 5'h02;
	localparam logic [4:0] OP_CALL         = 5'h03;
	localparam logic [4:0] OP_RETURN       = 5'h04;
	localparam logic [4:0] OP_HALT         = 5'h05;
	localparam logic [4:0] OP_IRQ          = 5'h06;
	localparam logic [4:0] OP_CMP_MSG_TMR  = 5'h07;
	localparam logic [4:0] OP_CMP_FRM_TMR  = 5'h08;
	localparam logic [4:0] OP_FLAG_BITS    = 5'h09;
	localparam logic [4:0] OP_EXEC_FLIP    = 5'h0A;
	localparam logic [4:0] OP_LOAD_TTAG    = 5'h0B;
	localparam logic [4:0] OP_LOAD_FRAME   = 5'h0C;
	localparam logic [4:0] OP_START_FRAME  = 5'h0D;
	localparam logic [4:0] OP_WAIT_TRIG    = 5'h0E;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_FETCH    = 4'b0001,
		ST_DECODE   = 4'b0010,
		ST_PARAM    = 4'b0011,
		ST_EXEC     = 4'b0100,
		ST_MSG_RD   = 4'b0101,
		ST_MSG_RUN  = 4'b0110,
		ST_GAP_WAIT = 4'b0111,
		ST_TRIG     = 4'b1000,
		ST_HALTED   = 4'b1001
	} seq_state_e;
endpackage : op_seq_pkg

// file: cond_eval.sv
// condition code evaluator for the op code sequencer
`timescale 1ns/100ps
module cond_eval
	import op_seq_pkg::*;
(
	input  wire logic [4:0] cond_code,
	input  wire logic [7:0] general_flags,
	input  wire logic       no_reply_flag,
	input  wire logic       format_fault_flag,
	input  wire logic       error_free_read_flag,
	input  wire logic       masked_status_flag,
	input  wire logic       loopback_fault,
	input  wire logic [1:0] retry_count,
	output logic            cond_true
);
	logic       invert;
	logic [3:0] sel;
	logic       bad_message_test;
	logic       one_retry_test;
	logic       two_retry_test;

	assign invert = cond_code[COND_INV_BIT];
	assign sel    = cond_code[3:0];
	// masked status deliberately left out of this term
	assign bad_message_test = format_fault_flag | no_reply_flag | loopback_fault;
	assign one_retry_test   = (retry_count != 2'd0);
	assign two_retry_test   = (retry_count == 2'd2);

	always_comb begin
		cond_true = 1'b0;
		case (sel)
			COND_NO_REPLY:   cond_true = no_reply_flag ^ invert;
			COND_FORMAT:     cond_true = format_fault_flag ^ invert;
			COND_ERROR_FREE_READ_FLAG:  cond_true = error_free_read_flag ^ invert;
			COND_MASKED:     cond_true = masked_status_flag ^ invert;
			COND_BAD_MSG:    cond_true = bad_message_test ^ invert;
			COND_RETRY_1:    cond_true = invert ? (retry_count == 2'd0) : one_retry_test;
			// undefined inverse: treated as false
			COND_RETRY_2:    cond_true = invert ? 1'b0 : two_retry_test;
			COND_ALWAYS:     cond_true = ~invert;
			default:         cond_true = general_flags[sel[2:0]] ^ invert;
		endcase
	end
endmodule : cond_eval

// file: op_seq_asserts.sv
// port assertions for the op code sequencer
`timescale 1ns/100ps
module op_seq_asserts
	import op_seq_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              ce,
	input wire logic              host_flag_wr,
	input wire logic [7:0]        host_flag_data,
	input wire logic              stack_irq_enable,
	input wire logic              ram_rd,
	input wire logic [ADDR_W-1:0] ram_addr,
	input wire logic [WORD_W-1:0] ram_rdata,
	input wire logic              ram_rvalid,
	input wire logic              msg_start,
	input wire logic [ADDR_W-1:0] msg_block_addr,
	input wire logic              ttag_load,
	input wire logic              frame_load,
	input wire logic [WORD_W-1:0] load_value,
	input wire logic [7:0]        general_flags,
	input wire logic [3:0]        irq_code,
	input wire logic              irq_req,
	input wire logic              call_stack_fault_irq
);
	logic [15:0] w1_r;
	logic [15:0] w0_r;

	// last two words answered by memory
	always_ff @(posedge clk) begin
		if (ram_rvalid) begin
			w1_r <= ram_rdata;
			w0_r <= w1_r;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_answer;
		ram_rvalid ##[1:2] msg_start;
	endsequence

	a_reset_quiet: assert property ($fell(rst) |-> !ram_rd && !msg_start && !irq_req
		&& general_flags == GFLAG_RESET && irq_code == IRQ_RESET)
		else $error("outputs not clear after reset");
	a_rd_pulse: assert property (ram_rd |=> !ram_rd || !$past(ce))
		else $error("read strobe longer than one cycle");
	a_msg_pulse: assert property (msg_start |=> !msg_start || !$past(ce))
		else $error("message start longer than one cycle");
	a_ce_freeze: assert property (!ce |=> $stable(ram_addr) && $stable(irq_code))
		else $error("state moved while frozen");
	a_host_flag: assert property (host_flag_wr && ce |=> general_flags == $past(host_flag_data))
		else $error("host flag write lost");
	a_stack_gate: assert property (call_stack_fault_irq |-> $past(stack_irq_enable))
		else $error("stack fault while disabled");
	a_irq_code: assert property (irq_req |-> irq_code == w1_r[3:0])
		else $error("irq code not from parameter");
	a_load_value: assert property (ttag_load || frame_load |-> load_value == w1_r)
		else $error("load value not from parameter");
	a_msg_block: assert property (s_answer |-> msg_block_addr == w0_r)
		else $error("block address not from parameter");
	a_msg_cause: assert property (msg_start |-> $past(ram_rvalid) || $past(ram_rvalid, 2))
		else $error("message start without block word");
endmodule : op_seq_asserts

bind op_sequencer op_seq_asserts chk (.clk(clk), .rst(rst), .ce(ce), .host_flag_wr(host_flag_wr),
	.host_flag_data(host_flag_data), .stack_irq_enable(stack_irq_enable), .ram_rd(ram_rd),
	.ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid), .msg_start(msg_start),
	.msg_block_addr(msg_block_addr), .ttag_load(ttag_load), .frame_load(frame_load),
	.load_value(load_value), .general_flags(general_flags), .irq_code(irq_code),
	.irq_req(irq_req), .call_stack_fault_irq(call_stack_fault_irq));

// file: host_model.sv
// instruction memory and message engine facing the sequencer
`timescale 1ns/100ps
module host_model (
	input  wire logic        clk,
	input  wire logic        ram_rd,
	input  wire logic [15:0] ram_addr,
	input  wire logic        msg_start,
	output logic [15:0]      ram_rdata,
	output logic             ram_rvalid,
	output logic             msg_done
);
	logic [15:0] mem [256];
	logic [7:0]  addr_r;
	int          lat = 1;
	int          cnt = 0;
	int          run_cnt = 0;

	initial begin
		ram_rdata = 16'h5A5A;
		ram_rvalid = 1'b0;
		msg_done = 1'b0;
	end

	// idle data flips each cycle so a stale word never looks fresh
	always @(posedge clk) begin
		ram_rvalid <= (ram_rd !== 1'b1 && cnt == 1);
		ram_rdata  <= (ram_rd !== 1'b1 && cnt == 1) ? mem[addr_r] : ~ram_rdata;
		if (ram_rd === 1'b1) begin
			addr_r <= ram_addr[7:0];
			cnt    <= lat;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end

	// message takes three cycles on the bus
	always @(posedge clk) begin
		msg_done <= (run_cnt == 1);
		if (msg_start === 1'b1) run_cnt <= 3;
		else if (run_cnt > 0) run_cnt <= run_cnt - 1;
	end
endmodule : host_model

// file: testbench.sv
// self-checking bench for the op code sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench
	import op_seq_pkg::*;
;
	typedef struct packed {
		logic [4:0] cond;
		logic [7:0] gf;
		logic [4:0] err;
		logic [1:0] rty;
		logic       take;
	} row_s;
	logic        clk, rst, ce, start, ext_trigger, stack_irq_enable, host_flag_wr;
	logic        msg_done, no_reply_flag, format_fault_flag, error_free_read_flag;
	logic        masked_status_flag, loopback_fault, ram_rvalid, ram_rd, msg_start;
	logic        ttag_load, frame_load, frame_start, irq_req, call_stack_fault_irq, busy, halted;
	logic [1:0]  retry_count;
	logic [3:0]  irq_code;
	logic [7:0]  host_flag_data, general_flags;
	logic [15:0] ram_rdata, ram_addr, msg_block_addr, load_value, frame_time_left, blk;
	int          bad_count, n_tests, cyc, n_irq, n_flt, n_ev, n_msg, n_rd0, t_msg, t_rd, d;
	row_s        rows [20] = '{
		'{5'h0C, 8'h00, 5'h10, 2'h0, 1'b1}, '{5'h0C, 8'h00, 5'h01, 2'h0, 1'b1},
		'{5'h0C, 8'h00, 5'h08, 2'h0, 1'b1}, '{5'h0C, 8'h00, 5'h02, 2'h0, 1'b0},
		'{5'h1C, 8'h00, 5'h02, 2'h0, 1'b1}, '{5'h0D, 8'h00, 5'h00, 2'h1, 1'b1},
		'{5'h0D, 8'h00, 5'h00, 2'h2, 1'b1}, '{5'h0D, 8'h00, 5'h00, 2'h0, 1'b0},
		'{5'h1D, 8'h00, 5'h00, 2'h0, 1'b1}, '{5'h1D, 8'h00, 5'h00, 2'h1, 1'b0},
		'{5'h0E, 8'h00, 5'h00, 2'h2, 1'b1}, '{5'h0E, 8'h00, 5'h00, 2'h1, 1'b0},
		'{5'h1E, 8'h00, 5'h00, 2'h2, 1'b0}, '{5'h1F, 8'h00, 5'h00, 2'h0, 1'b0},
		'{5'h13, 8'h08, 5'h00, 2'h0, 1'b0}, '{5'h03, 8'h08, 5'h00, 2'h0, 1'b1},
		'{5'h18, 8'h00, 5'h10, 2'h0, 1'b0}, '{5'h09, 8'h00, 5'h08, 2'h0, 1'b1},
		'{5'h0A, 8'h00, 5'h04, 2'h0, 1'b1}, '{5'h1B, 8'h00, 5'h02, 2'h0, 1'b0}};

	op_sequencer DUT (.clk(clk), .rst(rst), .ce(ce), .start(start), .ext_trigger(ext_trigger),
		.stack_irq_enable(stack_irq_enable), .host_flag_wr(host_flag_wr),
		.host_flag_data(host_flag_data), .ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid),
		.msg_done(msg_done), .no_reply_flag(no_reply_flag), .format_fault_flag(format_fault_flag),
		.error_free_read_flag(error_free_read_flag), .masked_status_flag(masked_status_flag),
		.loopback_fault(loopback_fault), .retry_count(retry_count),
		.frame_time_left(frame_time_left), .ram_rd(ram_rd), .ram_addr(ram_addr),
		.msg_start(msg_start), .msg_block_addr(msg_block_addr), .ttag_load(ttag_load),
		.frame_load(frame_load), .frame_start(frame_start), .load_value(load_value),
		.general_flags(general_flags), .irq_code(irq_code), .irq_req(irq_req),
		.call_stack_fault_irq(call_stack_fault_irq), .busy(busy), .halted(halted));
	host_model host (.clk(clk), .ram_rd(ram_rd), .ram_addr(ram_addr), .msg_start(msg_start),
		.ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid), .msg_done(msg_done));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (irq_req === 1'b1) n_irq++;
		if (call_stack_fault_irq === 1'b1) n_flt++;
		if ((ttag_load | frame_load | frame_start) === 1'b1) n_ev++;
		if (ram_rd === 1'b1 && ram_addr === 16'h0000) n_rd0++;
		if (ram_rd === 1'b1 && n_msg > 0 && t_rd == 0) t_rd = cyc;
		if (msg_start === 1'b1) begin
			n_msg++;
			t_msg = cyc;
			blk = msg_block_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic reset_dut(input int n);
		rst = 1'b1;
		tick(n);
		rst = 1'b0;
		{n_irq, n_flt, n_ev, n_msg, n_rd0, t_rd} = '0;
	endtask : reset_dut
	task automatic host_wr(input logic [7:0] v);
		host_flag_wr = 1'b1;
		host_flag_data = v;
		tick(1);
		host_flag_wr = 1'b0;
	endtask : host_wr
	task automatic put(input int a, input logic [15:0] w, input logic [15:0] p);
		host.mem[a] = w;
		host.mem[a+1] = p;
	endtask : put
	function automatic logic [15:0] op(input logic [4:0] ins, input logic [4:0] cnd);
		return {1'b0, ins, 5'h00, cnd};
	endfunction : op
	task automatic wait_halt(input int lim);
		for (int k = 0; k < lim && halted !== 1'b1; k++) tick(1);
	endtask : wait_halt
	task automatic run(input int lim, input bit pause);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		if (pause) begin
			for (int k = 0; k < 200 && n_msg == 0; k++) tick(1);
			tick(5);
			ce = 1'b0; // frozen cycles stretch the gap
			tick(10);
			ce = 1'b1;
		end
		wait_halt(lim);
	endtask : run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test

	initial begin
		#500000;
		bad_count++;
		$display("test watchdog expired");
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, ce, ext_trigger, stack_irq_enable, start, host_flag_wr} = 6'h3C;
		{no_reply_flag, format_fault_flag, error_free_read_flag} = 3'h0;
		{masked_status_flag, loopback_fault, retry_count, host_flag_data} = 12'h000;
		frame_time_left = 16'h0100;
		reset_dut(20);
		`CHK("flags", GFLAG_RESET, general_flags)
		`CHK("irq", IRQ_RESET, irq_code)
		`CHK("halted", 1'b0, halted)
		`CHK("busy", 1'b0, busy)
		$display("test reset done");
		foreach (rows[i]) begin
			reset_dut(2);
			{no_reply_flag, format_fault_flag, error_free_read_flag, masked_status_flag,
				loopback_fault} = rows[i].err;
			retry_count = rows[i].rty;
			host_wr(rows[i].gf);
			put(0, {1'b1, OP_IRQ, 5'h1F, rows[i].cond}, {12'h000, 4'(i) | 4'h1});
			put(2, op(OP_HALT, 5'h0F), 16'h0000);
			run(80, 1'b0);
			`CHK("taken", rows[i].take, n_irq)
			`CHK("code", rows[i].take ? 4'(i) | 4'h1 : IRQ_RESET, irq_code)
		end
		$display("test conditions done");
		reset_dut(2);
		host_wr(8'h80);
		ext_trigger = 1'b0;
		put(0, op(OP_FLAG_BITS, 5'h1F), 16'h880D);
		put(2, op(OP_LOAD_TTAG, 5'h1F), 16'h1111);
		put(4, op(OP_LOAD_TTAG, 5'h0F), 16'h1234);
		put(6, op(OP_LOAD_FRAME, 5'h0F), 16'h00FF);
		put(8, op(OP_START_FRAME, 5'h0F), 16'h0000);
		put(10, op(OP_WAIT_TRIG, 5'h0F), 16'h0000);
		put(12, op(OP_CMP_MSG_TMR, 5'h1F), 16'h0000);
		put(14, op(OP_JUMP, 5'h01), 16'h0012);
		// trap: landing here means the jump was not taken
		put(16, op(OP_HALT, 5'h0F), 16'h0000);
		put(18, op(OP_CMP_FRM_TMR, 5'h1F), 16'h0200);
		put(20, op(OP_HALT, 5'h0F), 16'h0000);
		run(100, 1'b0);
		`CHK("trigger hold", 1'b0, halted)
		`CHK("busy", 1'b1, busy)
		`CHK("events", 3, n_ev)
		ext_trigger = 1'b1;
		wait_halt(80);
		`CHK("halt", 1'b1, halted)
		`CHK("flags", 8'h0D, general_flags)
		$display("test unconditional done");
		reset_dut(2);
		put(0, op(OP_CALL, 5'h0F), 16'h0000);
		put(2, op(OP_RETURN, 5'h0F), 16'h0000);
		put(4, op(OP_HALT, 5'h0F), 16'h0000);
		run(400, 1'b0);
		`CHK("calls", STACK_DEPTH + 1, n_rd0)
		`CHK("stack faults", 2, n_flt)
		for (int e = 0; e < 2; e++) begin
			stack_irq_enable = e[0];
			reset_dut(2);
			put(0, op(OP_RETURN, 5'h0F), 16'h0000);
			run(60, 1'b0);
			`CHK("underflow", 2 * e, n_flt)
		end
		$display("test stack done");
		for (int m = 0; m < 3; m++) begin
			reset_dut(2);
			host.lat = m + 1;
			host.mem[16'h43] = (m == 2) ? 16'h0028 : 16'h0000;
			put(0, op(m == 1 ? OP_EXEC_FLIP : OP_EXEC_MSG, m == 2 ? 5'h0F : 5'h1F),
				16'h0040);
			put(2, op(OP_HALT, 5'h0F), 16'h0000);
			run(300, m == 2);
			d = t_rd - t_msg;
			`CHK("msgs", m > 0, n_msg)
			`CHK("flip", m == 1, general_flags[0])
			if (m > 0) `CHK("block", 16'h0040, blk)
			if (m == 1) `CHK("short gap", 1'b1, d >= 2 && d <= 12)
			if (m == 2) `CHK("gap", 1'b1, d >= 47 && d <= 56)
		end
		$display("test message done");
		end_of_test();
	end
endmodule : testbench
